// ===== rtl/thermal_event_pkg.sv
// package: constants and carrier types for the thermal event configuration register
package thermal_event_pkg;

	// =====================================================
	// field positions
	localparam int MODE_BIT     = 0;
	localparam int POL_BIT      = 1;
	localparam int CRIT_BIT     = 2;
	localparam int OUT_EN_BIT   = 3;
	localparam int STATUS_BIT   = 4;
	localparam int CLEAR_BIT    = 5;
	localparam int ALARM_LK_BIT = 6;
	localparam int CRIT_LK_BIT  = 7;
	localparam int SHDN_BIT     = 8;
	localparam int HYS_LO_BIT   = 9;
	localparam int HYS_HI_BIT   = 10;

	// =====================================================
	// reset values
	localparam logic [1:0] HYS_RESET  = 2'h0;
	localparam logic       BIT_RESET  = 1'b0;

	// =====================================================
	// hysteresis in quarter degrees (temperature lsb = 0.25 C)
	localparam logic [4:0] HYS_OFF_Q  = 5'h00;
	localparam logic [4:0] HYS_1P5_Q  = 5'h06;
	localparam logic [4:0] HYS_3_Q    = 5'h0C;
	localparam logic [4:0] HYS_6_Q    = 5'h18;

	typedef enum logic [1:0]
	{
		ALERT_IDLE    = 2'b00,
		ALERT_PENDING = 2'b01,
		ALERT_CLEARED = 2'b10
	} alert_state_type;

	typedef struct packed
	{
		logic        crit_lock;
		logic        alarm_lock;
		logic [1:0]  hysteresis_amount;
		logic        shutdown;
		logic        out_en;
		logic        crit_only;
		logic        polarity;
		logic        int_mode;
	} cfg_type;

	typedef struct packed
	{
		logic        above;
		logic        below;
		logic        crit;
	} trip_type;

	typedef struct packed
	{
		cfg_type         cfg;
		trip_type        trip;
		alert_state_type ast;
		logic            status;
		logic            alert_pin;
		logic [15:0]     rdata;
		logic            conv_en;
	} state_type;

endpackage : thermal_event_pkg

// ===== rtl/thermal_event_config_register.sv
// module: thermal event configuration register with alert generation
`timescale 1ns/1ps

// Summary of operation
// - bit 0 picks comparator (0, reset) or interrupt (1) alert behaviour
// - writes to mode bit ignored while any lock bit set
// - bit 1 polarity, 0 active-low at reset; locked by either lock
// - bit 2 critical-only filter, reset 0; locked by alarm lock only
// - bit 3 enables alert output, reset 0; locked by either lock
// - read-only bit 4 shows whether the alert output is asserted
// - writing 1 to bit 5 clears the alert in interrupt mode
// - clear-alert bit always reads zero
// - in comparator mode clear-alert has no effect
// - bit 6 set blocks alarm window limit writes; reads back 1
// - bit 7 set blocks critical limit writes; reads 1; reset 0
// - lock bits stay set until power-on reset
// - a single write sets a lock bit
// - bit 8 shutdown stops conversion and suppresses alerts; reset 0
// - setting shutdown ignored while locked; clearing always accepted
// - bits 10:9 hysteresis: off, 1.5, 3, 6 degrees
// - at critical trip alert behaves as comparator, clear has no effect
// - comparator alert follows temperature only, not register accesses
// - above-window holds until temperature at or below upper minus hysteresis
// - interrupt-mode alert triggers on entering or leaving the alarm window
module thermal_event_config_register
(
	input  wire logic               clk_i,
	input  wire logic               reset_n_i,
	input  wire logic               cfg_wr_i,
	input  wire logic [15:0]        cfg_wdata_i,
	input  wire logic               cfg_rd_i,
	output logic      [15:0]        cfg_rdata_o,
	input  wire logic               temp_valid_i,
	input  wire logic signed [12:0] temp_i,
	input  wire logic signed [12:0] upper_limit_i,
	input  wire logic signed [12:0] lower_limit_i,
	input  wire logic signed [12:0] crit_limit_i,
	input  wire logic               alarm_limit_wr_i,
	input  wire logic               crit_limit_wr_i,
	output logic                    alarm_limit_wr_ok_o,
	output logic                    crit_limit_wr_ok_o,
	output logic                    conv_en_o,
	output logic                    above_o,
	output logic                    below_o,
	output logic                    crit_o,
	output logic                    alert_oe_n_o
);

	thermal_event_pkg::state_type state_ff;
	thermal_event_pkg::state_type nxt_state;
	logic                         wr_alarm_ok_ff;
	logic                         wr_crit_ok_ff;

	// =====================================================
	// hysteresis decode
	function automatic logic [4:0] hys_q(input logic [1:0] sel);
		case (sel)
			2'h0:    hys_q = thermal_event_pkg::HYS_OFF_Q;
			2'h1:    hys_q = thermal_event_pkg::HYS_1P5_Q;
			2'h2:    hys_q = thermal_event_pkg::HYS_3_Q;
			default: hys_q = thermal_event_pkg::HYS_6_Q;
		endcase
	endfunction : hys_q

	// =====================================================
	// next state
	logic                   any_lock;
	logic                   clear_req;
	logic signed [13:0]     hys_s;
	logic signed [13:0]     t_s;
	logic                   window_change;
	logic                   cond;
	logic                   in_crit;
	logic                   asserted;

	always_comb
	begin
		nxt_state = state_ff;
		any_lock  = state_ff.cfg.alarm_lock | state_ff.cfg.crit_lock;
		clear_req = 1'b0;
		hys_s     = 14'(signed'({1'b0, hys_q(state_ff.cfg.hysteresis_amount)}));
		t_s       = 14'(temp_i);
		window_change = 1'b0;

		// register write; bits 15:11 dropped, status and clear not stored
		if (cfg_wr_i)
		begin
			if (!any_lock)
			begin
				nxt_state.cfg.int_mode = cfg_wdata_i[thermal_event_pkg::MODE_BIT];
				nxt_state.cfg.polarity = cfg_wdata_i[thermal_event_pkg::POL_BIT];
				nxt_state.cfg.out_en   = cfg_wdata_i[thermal_event_pkg::OUT_EN_BIT];
			end
			if (!state_ff.cfg.alarm_lock)
				nxt_state.cfg.crit_only = cfg_wdata_i[thermal_event_pkg::CRIT_BIT];
			// locks are sticky: only set by one write, never cleared here
			nxt_state.cfg.alarm_lock = state_ff.cfg.alarm_lock
				| cfg_wdata_i[thermal_event_pkg::ALARM_LK_BIT];
			nxt_state.cfg.crit_lock  = state_ff.cfg.crit_lock
				| cfg_wdata_i[thermal_event_pkg::CRIT_LK_BIT];
			if (!cfg_wdata_i[thermal_event_pkg::SHDN_BIT] || !any_lock)
				nxt_state.cfg.shutdown = cfg_wdata_i[thermal_event_pkg::SHDN_BIT];
			nxt_state.cfg.hysteresis_amount =
				cfg_wdata_i[thermal_event_pkg::HYS_HI_BIT:thermal_event_pkg::HYS_LO_BIT];
			clear_req = cfg_wdata_i[thermal_event_pkg::CLEAR_BIT];
		end

		nxt_state.conv_en = ~nxt_state.cfg.shutdown;

		// trip detection; hysteresis on de-assertion for above and crit, on assertion for below; frozen in shutdown
		if (temp_valid_i && !state_ff.cfg.shutdown)
		begin
			if (t_s > 14'(upper_limit_i))
				nxt_state.trip.above = 1'b1;
			else if (t_s <= 14'(upper_limit_i) - hys_s)
				nxt_state.trip.above = 1'b0;
			if (t_s < 14'(lower_limit_i) - hys_s)
				nxt_state.trip.below = 1'b1;
			else if (t_s >= 14'(lower_limit_i))
				nxt_state.trip.below = 1'b0;
			if (t_s >= 14'(crit_limit_i))
				nxt_state.trip.crit = 1'b1;
			else if (t_s < 14'(crit_limit_i) - hys_s)
				nxt_state.trip.crit = 1'b0;
			window_change = (nxt_state.trip.above != state_ff.trip.above)
				| (nxt_state.trip.below != state_ff.trip.below);
		end

		in_crit = nxt_state.trip.crit;
		cond    = nxt_state.cfg.crit_only ? in_crit
			: (nxt_state.trip.above | nxt_state.trip.below | in_crit);

		// interrupt-mode latch; comparator mode ignores clear entirely
		case (state_ff.ast)
			thermal_event_pkg::ALERT_IDLE:
			begin
				if (window_change && !nxt_state.cfg.crit_only)
					nxt_state.ast = thermal_event_pkg::ALERT_PENDING;
			end
			thermal_event_pkg::ALERT_PENDING:
			begin
				// trigger wins over a clear arriving in the same cycle
				if (clear_req && state_ff.cfg.int_mode && !window_change)
					nxt_state.ast = thermal_event_pkg::ALERT_CLEARED;
			end
			thermal_event_pkg::ALERT_CLEARED:
			begin
				if (window_change)
					nxt_state.ast = thermal_event_pkg::ALERT_PENDING;
				else
					nxt_state.ast = thermal_event_pkg::ALERT_IDLE;
			end
			default: nxt_state.ast = thermal_event_pkg::ALERT_IDLE;
		endcase

		// critical forces comparator behaviour, clear cannot remove it
		if (in_crit)
			asserted = 1'b1;
		else if (nxt_state.cfg.int_mode)
			asserted = (nxt_state.ast == thermal_event_pkg::ALERT_PENDING);
		else
			asserted = cond;

		nxt_state.status = asserted & nxt_state.cfg.out_en
			& ~nxt_state.cfg.shutdown;
		nxt_state.alert_pin = nxt_state.status ^ ~nxt_state.cfg.polarity;

		// read-back image; reserved bits and clear bit read zero
		nxt_state.rdata = 16'h0000;
		nxt_state.rdata[thermal_event_pkg::MODE_BIT]     = nxt_state.cfg.int_mode;
		nxt_state.rdata[thermal_event_pkg::POL_BIT]      = nxt_state.cfg.polarity;
		nxt_state.rdata[thermal_event_pkg::CRIT_BIT]     = nxt_state.cfg.crit_only;
		nxt_state.rdata[thermal_event_pkg::OUT_EN_BIT]   = nxt_state.cfg.out_en;
		nxt_state.rdata[thermal_event_pkg::STATUS_BIT]   = nxt_state.status;
		nxt_state.rdata[thermal_event_pkg::ALARM_LK_BIT] = nxt_state.cfg.alarm_lock;
		nxt_state.rdata[thermal_event_pkg::CRIT_LK_BIT]  = nxt_state.cfg.crit_lock;
		nxt_state.rdata[thermal_event_pkg::SHDN_BIT]     = nxt_state.cfg.shutdown;
		nxt_state.rdata[thermal_event_pkg::HYS_HI_BIT:thermal_event_pkg::HYS_LO_BIT] =
			nxt_state.cfg.hysteresis_amount;
	end

	// =====================================================
	// registers; only power-on reset clears locks
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state_ff           <= '0;
			state_ff.alert_pin <= 1'b1;
			state_ff.conv_en   <= 1'b1;
			wr_alarm_ok_ff     <= 1'b0;
			wr_crit_ok_ff      <= 1'b0;
		end
		else
		begin
			state_ff       <= nxt_state;
			wr_alarm_ok_ff <= alarm_limit_wr_i & ~state_ff.cfg.alarm_lock;
			wr_crit_ok_ff  <= crit_limit_wr_i & ~state_ff.cfg.crit_lock;
		end
	end

	// =====================================================
	// outputs, all from flip-flops
	logic unused_rd;
	assign unused_rd = cfg_rd_i;

	assign cfg_rdata_o         = state_ff.rdata;
	assign alarm_limit_wr_ok_o = wr_alarm_ok_ff;
	assign crit_limit_wr_ok_o  = wr_crit_ok_ff;
	assign conv_en_o           = state_ff.conv_en;
	assign above_o             = state_ff.trip.above;
	assign below_o             = state_ff.trip.below;
	assign crit_o              = state_ff.trip.crit;
	// open drain: oe_n low pulls the pin low
	assign alert_oe_n_o        = state_ff.alert_pin;

endmodule : thermal_event_config_register

// ===== dv/thermal_event_chk.sv
// checker: port-level assertions for the thermal event configuration register
`timescale 1ns/1ps
module thermal_event_chk
(
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        cfg_wr_i,
	input  wire logic [15:0] cfg_wdata_i,
	input  wire logic [15:0] cfg_rdata_o,
	input  wire logic        alarm_limit_wr_i,
	input  wire logic        crit_limit_wr_i,
	input  wire logic        alarm_limit_wr_ok_o,
	input  wire logic        crit_limit_wr_ok_o,
	input  wire logic        conv_en_o
);
	// ==========
	// properties
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	wire logic locked = cfg_rdata_o[6] | cfg_rdata_o[7];

	rsv_zero_a : assert property (
		cfg_rdata_o[15:11] == 5'h00 && !cfg_rdata_o[5]) else $error("reserved bits nonzero");
	lock_sticky_a : assert property (
		($past(cfg_rdata_o[7:6]) & ~cfg_rdata_o[7:6]) == 2'h0) else $error("lock bit fell");
	lock_write_a : assert property (
		cfg_wr_i |=> (cfg_rdata_o[7:6] & $past(cfg_wdata_i[7:6])) == $past(cfg_wdata_i[7:6]))
		else $error("lock bit not set by one write");
	alarm_gate_a : assert property (
		alarm_limit_wr_i |=> alarm_limit_wr_ok_o == !$past(cfg_rdata_o[6]))
		else $error("alarm limit gate wrong");
	crit_gate_a : assert property (
		crit_limit_wr_i |=> crit_limit_wr_ok_o == !$past(cfg_rdata_o[7]))
		else $error("critical limit gate wrong");
	locked_hold_a : assert property (
		cfg_wr_i && locked |=> $stable(cfg_rdata_o[3]) && $stable(cfg_rdata_o[1:0])
		&& (!$past(cfg_rdata_o[6]) || $stable(cfg_rdata_o[2]))) else $error("locked field moved");
	shdn_lock_a : assert property (
		cfg_wr_i && locked && !cfg_rdata_o[8] |=> !cfg_rdata_o[8]) else $error("shutdown set");
	conv_en_a : assert property (
		conv_en_o == !cfg_rdata_o[8]) else $error("converter enable wrong");
	status_gate_a : assert property (
		cfg_rdata_o[4] |-> cfg_rdata_o[3] && !cfg_rdata_o[8]) else $error("status while gated");
endmodule : thermal_event_chk

bind thermal_event_config_register thermal_event_chk i_chk
(
	.clk_i(clk_i), .reset_n_i(reset_n_i), .cfg_wr_i(cfg_wr_i), .cfg_wdata_i(cfg_wdata_i),
	.cfg_rdata_o(cfg_rdata_o), .alarm_limit_wr_i(alarm_limit_wr_i),
	.crit_limit_wr_i(crit_limit_wr_i), .alarm_limit_wr_ok_o(alarm_limit_wr_ok_o),
	.crit_limit_wr_ok_o(crit_limit_wr_ok_o), .conv_en_o(conv_en_o)
);

// ===== dv/cfg_host_model.sv
// host model: bus side that writes and reads the configuration word
`timescale 1ns/1ps
module cfg_host_model
(
	input  wire logic        clk_i,
	output logic             cfg_wr_o,
	output logic [15:0]      cfg_wdata_o,
	output logic             cfg_rd_o,
	input  wire logic [15:0] cfg_rdata_i
);
	// ==========
	// transfers
	initial
	begin
		cfg_wr_o = 1'b0;
		cfg_rd_o = 1'b0;
		cfg_wdata_o = 16'h0000;
	end
	// one strobe per word; released data is inverted so stale values never match
	task automatic wr(input logic [15:0] d);
		@(posedge clk_i);
		cfg_wr_o <= 1'b1;
		cfg_wdata_o <= d;
		@(posedge clk_i);
		cfg_wr_o <= 1'b0;
		cfg_wdata_o <= ~d;
		#1;
	endtask : wr
	task automatic rd(output logic [15:0] q);
		@(posedge clk_i);
		cfg_rd_o <= 1'b1;
		@(posedge clk_i);
		q = cfg_rdata_i;
		cfg_rd_o <= 1'b0;
		#1;
	endtask : rd
endmodule : cfg_host_model

// ===== dv/tb.sv
// testbench: directed scenarios for the thermal event configuration register
`timescale 1ns/1ps
module tb;
	logic        clk_i = 1'b0, reset_n_i = 1'b0, temp_valid_i = 1'b0;
	logic        alarm_limit_wr_i = 1'b0, crit_limit_wr_i = 1'b0;
	logic [12:0] temp_i = 13'h0000;
	// limits in quarter degrees: upper 25 C, lower 5 C, critical 50 C
	logic [12:0] upper_lim = 13'h0064, lower_lim = 13'h0014, crit_lim = 13'h00C8;
	logic [15:0] cfg_wdata_i, cfg_rdata_o;
	logic        cfg_wr_i, cfg_rd_i, alarm_ok, crit_ok, conv_en_o;
	logic        above_o, below_o, crit_o, alert_oe_n_o;
	int          n_errors = 0, comparisons = 0;
	always #20 clk_i = ~clk_i;
	cfg_host_model i_host (.clk_i(clk_i), .cfg_wr_o(cfg_wr_i), .cfg_wdata_o(cfg_wdata_i),
		.cfg_rd_o(cfg_rd_i), .cfg_rdata_i(cfg_rdata_o));
	thermal_event_config_register i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.cfg_wr_i(cfg_wr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rd_i(cfg_rd_i),
		.cfg_rdata_o(cfg_rdata_o), .temp_valid_i(temp_valid_i), .temp_i(temp_i),
		.upper_limit_i(upper_lim), .lower_limit_i(lower_lim), .crit_limit_i(crit_lim),
		.alarm_limit_wr_i(alarm_limit_wr_i), .crit_limit_wr_i(crit_limit_wr_i),
		.alarm_limit_wr_ok_o(alarm_ok), .crit_limit_wr_ok_o(crit_ok), .conv_en_o(conv_en_o),
		.above_o(above_o), .below_o(below_o), .crit_o(crit_o), .alert_oe_n_o(alert_oe_n_o));
	// ==========
	// helpers
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e)
		begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic rdchk(input logic [15:0] m, input logic [15:0] e);
		logic [15:0] q;
		i_host.rd(q);
		chk("config", e, q & m);
	endtask : rdchk
	task automatic samp(input logic [12:0] t);
		@(posedge clk_i);
		temp_valid_i <= 1'b1;
		temp_i <= t;
		@(posedge clk_i);
		temp_valid_i <= 1'b0;
		#1;
	endtask : samp
	task automatic lim(input logic a, input logic e);
		@(posedge clk_i);
		alarm_limit_wr_i <= a;
		crit_limit_wr_i <= !a;
		@(posedge clk_i);
		alarm_limit_wr_i <= 1'b0;
		crit_limit_wr_i <= 1'b0;
		#1;
		chk("limit_ok", {15'h0000, e}, {15'h0000, a ? alarm_ok : crit_ok});
	endtask : lim
	// ==========
	// scenarios
	task automatic t_basic();
		rdchk(16'hFFFF, 16'h0000);
		chk("conv_en", 16'h0001, conv_en_o);
		for (int k = 0; k < 4; k++)
		begin
			i_host.wr({5'h1F, k[1:0], 9'h02F});
			rdchk(16'hFFEF, {5'h00, k[1:0], 9'h00F});
		end
		i_host.wr(16'h0108);
		samp(13'h0078);
		chk("conv_en", 16'h0000, conv_en_o);
		rdchk(16'h0010, 16'h0000);
		$display("end basic");
	endtask : t_basic
	task automatic t_comp();
		i_host.wr(16'h0408);
		samp(13'h0078);
		chk("alert_oe_n", 16'h0000, alert_oe_n_o);
		rdchk(16'h0010, 16'h0010);
		i_host.wr(16'h0428);
		chk("alert_oe_n", 16'h0000, alert_oe_n_o);
		samp(13'h005F);
		chk("above", 16'h0001, above_o);
		samp(13'h0058);
		chk("above", 16'h0000, above_o);
		chk("alert_oe_n", 16'h0001, alert_oe_n_o);
		i_host.wr(16'h040A);
		samp(13'h0078);
		chk("alert_oe_n", 16'h0001, alert_oe_n_o);
		samp(13'h0058);
		samp(13'h0007);
		chk("below", 16'h0001, below_o);
		chk("alert_oe_n", 16'h0001, alert_oe_n_o);
		samp(13'h0058);
		chk("below", 16'h0000, below_o);
		$display("end comparator");
	endtask : t_comp
	task automatic t_int();
		i_host.wr(16'h0409);
		samp(13'h0078);
		chk("alert_oe_n", 16'h0000, alert_oe_n_o);
		i_host.wr(16'h0429);
		for (int i = 0; i < 4 && alert_oe_n_o !== 1'b1; i++) @(posedge clk_i) #1;
		chk("alert_oe_n", 16'h0001, alert_oe_n_o);
		samp(13'h00D2);
		i_host.wr(16'h0429);
		repeat (4) @(posedge clk_i);
		chk("crit", 16'h0001, crit_o);
		chk("alert_oe_n", 16'h0000, alert_oe_n_o);
		samp(13'h0058);
		i_host.wr(16'h0000);
		$display("end interrupt");
	endtask : t_int
	task automatic t_lock();
		lim(1'b1, 1'b1);
		lim(1'b0, 1'b1);
		i_host.wr(16'h0100);
		i_host.wr(16'h01C0);
		rdchk(16'hFFEF, 16'h01C0);
		lim(1'b1, 1'b0);
		lim(1'b0, 1'b0);
		i_host.wr(16'h000F);
		rdchk(16'hFFEF, 16'h00C0);
		i_host.wr(16'h0100);
		rdchk(16'hFFEF, 16'h00C0);
		@(posedge clk_i);
		reset_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		reset_n_i <= 1'b1;
		rdchk(16'hFFFF, 16'h0000);
		$display("end lock");
	endtask : t_lock
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize
	initial
	begin
		repeat (4) @(posedge clk_i);
		reset_n_i <= 1'b1;
		t_basic();
		t_comp();
		t_int();
		t_lock();
		summarize();
	end
endmodule : tb
